// ==== bench/boot_ack_ctrl_checker.sv ====
// port assertions of the boot acknowledge front end
`timescale 1ns/1ps
module boot_ack_ctrl_checker
  import boot_ack_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       linkClk,
  input wire logic       linkTxValid,
  input wire logic [7:0] linkTxData,
  input wire logic       linkRxEnable,
  input wire logic       linkSyncMode,
  input wire logic       eraseReq,
  input wire logic       eraseDone,
  input wire logic       eraseOk,
  input wire logic       opStart,
  input wire logic [7:0] opCode,
  input wire logic       modeSync,
  input wire logic       bootAbort
);
  // erase accepted, then a good finish from outside
  sequence eraseGood;
    eraseReq ##[1:300] (eraseDone && eraseOk);
  endsequence
  AST_ZERO: assert property (@(posedge linkClk) disable iff (!rst_b)
    linkTxValid && !(linkTxData inside {8'h86, 8'h54, 8'h4f, 8'h4c}) |->
    linkTxData[2:1] == ACK_ZERO_BITS) else $error("ack bits 2:1 set");
  AST_SYNC_NOERR: assert property (@(posedge linkClk) disable iff (!rst_b)
    linkTxValid && linkSyncMode |-> linkTxData[3:0] != 4'h8) else $error("clocked rx error");
  AST_PULSE: assert property (@(posedge linkClk) disable iff (!rst_b)
    linkTxValid |=> !linkTxValid) else $error("ack pulse too long");
  AST_RXEN: assert property (@(posedge linkClk) disable iff (!rst_b)
    linkRxEnable |=> linkRxEnable) else $error("reception enable dropped");
  AST_ABORT_QUIET: assert property (@(posedge linkClk) disable iff (!rst_b)
    bootAbort |-> !linkTxValid) else $error("ack after abort");
  AST_ABORT: assert property (@(posedge clk) disable iff (!rst_b)
    bootAbort |=> bootAbort && $stable(opCode)) else $error("abort not final");
  AST_MODE: assert property (@(posedge clk) disable iff (!rst_b)
    modeSync |=> modeSync) else $error("mode changed");
  AST_OP_OK: assert property (@(posedge clk) disable iff (!rst_b)
    opStart |-> opCode[3:0] == CMD_LOW_NIB) else $error("start on bad ack");
  AST_ERASE_OK: assert property (@(posedge clk) disable iff (!rst_b)
    eraseGood |-> ##[1:40] opCode == ERASE_DONE_OK) else $error("no erase done code");
endmodule // boot_ack_ctrl_checker
bind boot_ack_ctrl boot_ack_ctrl_checker u_chk (.clk, .rst_b, .linkClk, .linkTxValid,
  .linkTxData, .linkRxEnable, .linkSyncMode, .eraseReq, .eraseDone, .eraseOk, .opStart,
  .opCode, .modeSync, .bootAbort);

// ==== bench/boot_ack_ctrl_tb.sv ====
// self-checking bench of the boot acknowledge front end
`timescale 1ns/1ps
module boot_ack_ctrl_tb;
  import boot_ack_pkg::*;
  logic        clk, rst_b, linkClk, pwWrEn, eraseDone, eraseOk, rxdPin, linkRxValid;
  logic        linkRxErr, linkTxValid, linkRxEnable, linkSyncMode, eraseReq, opStart;
  logic        modeSync, bootAbort;
  logic [3:0]  pwWrAddr;
  logic [7:0]  pwWrData, linkRxData, linkTxData, opCode;
  logic [7:0]  ackQ [$];
  int          errors, tests_run, cyc;
  // command byte, error flag, expected ack
  logic [16:0] rows [6] = '{{8'h20, 1'b0, 8'h20}, {8'h30, 1'b0, 8'h30}, {8'h77, 1'b0, 8'h31},
                           {8'h20, 1'b0, 8'h20}, {8'h99, 1'b1, 8'h28}, {8'h30, 1'b0, 8'h30}};
  boot_ack_ctrl u_boot_ack_ctrl (.clk, .rst_b, .linkClk, .rxdPin, .linkRxValid, .linkRxData,
    .linkRxErr, .linkTxValid, .linkTxData, .linkRxEnable, .linkSyncMode, .pwWrEn, .pwWrAddr,
    .pwWrData, .eraseReq, .eraseDone, .eraseOk, .opStart, .opCode, .modeSync, .bootAbort);
  ctrl_model u_ctrl_model (.linkClk, .rxdPin, .linkRxValid, .linkRxData, .linkRxErr);
  initial begin clk = 1'b0; forever #2 clk = ~clk; end
  initial begin linkClk = 1'b0; #5; forever #16 linkClk = ~linkClk; end
  // collect every ack pulse
  always @(posedge linkClk) if (linkTxValid === 1'b1) ackQ.push_back(linkTxData);
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin errors++; close_out(); end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin $display("BAD %s exp %h got %h", n, e, g); errors++; end
  endtask
  // bounded wait for the next ack
  task automatic ack(input logic [7:0] e);
    int n = 0;
    while (ackQ.size() == 0 && n < 60) begin @(posedge linkClk); n++; end
    chk("ack", e, (ackQ.size() > 0) ? ackQ.pop_front() : 8'hxx);
  endtask
  task automatic sa(input logic [7:0] d, input logic e, input logic [7:0] x);
    u_ctrl_model.sendB(d, e);
    ack(x);
  endtask
  task automatic resetDut;
    rst_b <= 1'b0;
    repeat (5) @(posedge linkClk);
    @(posedge clk) rst_b <= 1'b1;
    ackQ.delete();
  endtask
  task automatic loadPw(input logic [7:0] b, input logic [7:0] s);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk) pwWrEn <= 1'b1;
      pwWrAddr <= 4'(i);
      pwWrData <= b + s * 8'(i);
    end
    @(posedge clk) pwWrEn <= 1'b0;
  endtask
  // ram transfer: command, 12 password bytes, checksum
  task automatic ramXfer(input logic [7:0] b, s, input logic e, input logic [7:0] x);
    logic [7:0] sum = 8'h00;
    sa(8'h10, 1'b0, 8'h10);
    for (int i = 0; i < 12; i++) begin
      sum += b + s * 8'(i);
      u_ctrl_model.sendB(b + s * 8'(i), 1'b0);
    end
    sa(8'h00 - sum, e, x);
  endtask
  task automatic erase(input logic ok, input logic [7:0] x);
    sa(8'h40, 1'b0, 8'h40);
    sa(ERASE_ENABLE, 1'b0, ERASE_ENABLE);
    @(posedge clk) eraseDone <= 1'b1;
    eraseOk <= ok;
    @(posedge clk) eraseDone <= 1'b0;
    ack(x);
  endtask
  initial begin
    {rst_b, pwWrEn, eraseDone, eraseOk, pwWrAddr, pwWrData} = 16'h0000;
    resetDut();
    loadPw(8'h30, 8'h01);
    u_ctrl_model.modeByte(4, 4, 8);
    ack(MODE_ACK_ASYNC);
    foreach (rows[i]) sa(rows[i][16:9], rows[i][8], rows[i][7:0]);
    ramXfer(8'h30, 8'h01, 1'b0, 8'h10);
    ramXfer(8'h31, 8'h01, 1'b0, 8'h11);
    ramXfer(8'h30, 8'h01, 1'b1, 8'h18);
    erase(1'b1, ERASE_DONE_OK);
    erase(1'b0, ERASE_DONE_BAD);
    $display("async done");
    resetDut();
    loadPw(8'h5a, 8'h00);
    u_ctrl_model.modeByte(5, 2, 2);
    ack(MODE_ACK_SYNC);
    chk("modeSync", 8'h01, {7'h00, modeSync});
    sa(8'h20, 1'b1, 8'h20);
    ramXfer(8'h5a, 8'h00, 1'b0, 8'h11);
    $display("clocked done");
    resetDut();
    u_ctrl_model.modeByte(1, 1, 2);
    chk("acks", 8'h00, 8'(ackQ.size()));
    chk("bootAbort", 8'h01, {7'h00, bootAbort});
    $display("abort done");
    close_out();
  end
endmodule // boot_ack_ctrl_tb

// ==== bench/ctrl_model.sv ====
// programming controller model: first-byte edges and link bytes
`timescale 1ns/1ps
module ctrl_model (
  input  wire logic       linkClk,
  output logic            rxdPin,
  output logic            linkRxValid,
  output logic      [7:0] linkRxData,
  output logic            linkRxErr
);
  initial begin
    rxdPin = 1'b1;
    linkRxValid = 1'b0;
    linkRxData = 8'h00;
    linkRxErr = 1'b0;
  end
  // first byte as four edges, gaps in link cycles
  task automatic modeByte(input int ab, input int bc, input int cd);
    @(posedge linkClk) rxdPin <= 1'b0;
    repeat (ab) @(posedge linkClk);
    rxdPin <= 1'b1;
    repeat (bc) @(posedge linkClk);
    rxdPin <= 1'b0;
    repeat (cd) @(posedge linkClk);
    rxdPin <= 1'b1;
    repeat (30) @(posedge linkClk);
  endtask
  // one byte pulse; released lines are scrambled, then a gap
  task automatic sendB(input logic [7:0] d, input logic e);
    @(posedge linkClk);
    linkRxValid <= 1'b1;
    linkRxData <= d;
    linkRxErr <= e;
    @(posedge linkClk);
    linkRxValid <= 1'b0;
    linkRxData <= ~d;
    linkRxErr <= ~e;
    repeat (8) @(posedge linkClk);
  endtask
endmodule // ctrl_model

// ==== hdl/boot_ack_ctrl.sv ====
// serial boot front end: mode detect, acknowledge coding, password check
`timescale 1ns/1ps
module boot_ack_ctrl (
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire logic                           linkClk,
  input  wire logic                           rxdPin,
  input  wire logic                           linkRxValid,
  input  wire logic [7:0]                     linkRxData,
  input  wire logic                           linkRxErr,
  output logic                                linkTxValid,
  output logic      [7:0]                     linkTxData,
  output logic                                linkRxEnable,
  output logic                                linkSyncMode,
  input  wire logic                           pwWrEn,
  input  wire logic [boot_ack_pkg::PW_AW-1:0] pwWrAddr,
  input  wire logic [7:0]                     pwWrData,
  output logic                                eraseReq,
  input  wire logic                           eraseDone,
  input  wire logic                           eraseOk,
  output logic                                opStart,
  output logic      [7:0]                     opCode,
  output logic                                modeSync,
  output logic                                bootAbort
);
  import boot_ack_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  boot_state_e      state_reg;          // main sequencer state
  boot_state_e      state_next;
  logic [TMR_W-1:0] timer_reg;          // free-running edge timer
  logic             rxdS1_reg;          // pin synchroniser
  logic             rxdS2_reg;
  logic             rxdS3_reg;          // previous synced level
  logic [1:0]       edgeCnt_reg;        // edges seen on first byte
  logic [TMR_W-1:0] edgeA_reg;          // time of first edge
  logic [TMR_W-1:0] second_edge_interval_reg;  // first-to-second interval
  logic [TMR_W-1:0] edgeC_reg;          // time of third edge
  logic [TMR_W-1:0] last_edge_interval;  // third-to-fourth interval
  logic             pinEdge;            // level change on synced pin
  logic             measDone;           // fourth edge seen now
  logic             isAsync;            // mode verdict
  logic             baudOk;             // async rate is usable
  logic             rxEnable_reg;       // serial reception allowed
  logic             modeSync_reg;       // clocked mode chosen
  logic             abort_reg;          // boot given up
  logic [3:0]       cmdNib_reg;         // nibble of executing command
  logic [3:0]       cmdNib_next;
  // rx crossing
  rx_byte_s         rxHold_reg;         // link domain byte holder
  logic             rxTog_reg;          // link domain event toggle
  logic             rxTogS1_reg;
  logic             rxTogS2_reg;
  logic             rxTogS3_reg;
  logic             rxStrobe;           // one byte arrived, clk domain
  logic             rxErr;              // error after mode masking
  // tx crossing
  logic [7:0]       txData_reg;         // ack byte held for link domain
  logic             txTog_reg;          // clk domain event toggle
  logic             txTogS1_reg;
  logic             txTogS2_reg;
  logic             txTogS3_reg;
  logic             enS1_reg;           // reception enable into link domain
  logic             enS2_reg;
  logic             synS1_reg;          // mode level into link domain
  logic             synS2_reg;
  logic             sendAck;            // emit ack this cycle
  logic [7:0]       ackByte;            // ack value to emit
  // password check
  logic [PW_AW-1:0] pwIdx_reg;          // next password byte index
  logic [7:0]       pwStored;           // stored byte at pwIdx_reg
  logic [7:0]       pwFirst_reg;        // first stored byte
  logic             pwSame_reg;         // stored bytes all identical so far
  logic             pwMiss_reg;         // a received byte differed
  logic             pwRxErr_reg;        // error seen among password bytes
  logic [7:0]       sum_reg;            // carry-dropped sum of covered bytes
  logic             areaErr;            // uniform non-blank stored area
  logic             sameNow;            // stored byte matches first
  // outputs held in flops
  logic             eraseReq_reg;
  logic             opStart_reg;
  logic [7:0]       opCode_reg;

  // ack layout: command nibble, error, two zeros, bad flag
  function automatic logic [7:0] makeAck(input logic [3:0] nib,
                                         input logic       err,
                                         input logic       bad);
    makeAck = {nib, err, ACK_ZERO_BITS, bad};  // [R1] [R2] [R3] [R4]
  endfunction

  // ----------------------------------------------------------------
  // first byte measurement
  // ----------------------------------------------------------------
  // free-running timer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_reg <= '0;
    end else begin
      timer_reg <= timer_reg + 1'b1;
    end
  end

  // pin synchroniser; only stage two and three are read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxdS1_reg <= 1'b1;
      rxdS2_reg <= 1'b1;
      rxdS3_reg <= 1'b1;
    end else begin
      rxdS1_reg <= rxdPin;
      rxdS2_reg <= rxdS1_reg;
      rxdS3_reg <= rxdS2_reg;
    end
  end

  // first edge must fall (start bit), later edges any direction
  assign pinEdge = (rxdS2_reg != rxdS3_reg) &&
                   ((edgeCnt_reg != 2'h0) || !rxdS2_reg);
  assign measDone = (state_reg == ST_MEASURE) && pinEdge && (edgeCnt_reg == EDGE_LAST);
  assign last_edge_interval = timer_reg - edgeC_reg;

  // timer capture at each transition while reception is off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      edgeCnt_reg              <= 2'h0;
      edgeA_reg                <= '0;
      second_edge_interval_reg <= '0;
      edgeC_reg                <= '0;
    end else if ((state_reg == ST_MEASURE) && pinEdge) begin
      edgeCnt_reg <= edgeCnt_reg + 2'h1;  // [R15]
      case (edgeCnt_reg)
        2'h0:    edgeA_reg <= timer_reg;
        2'h1:    second_edge_interval_reg <= timer_reg - edgeA_reg;
        2'h2:    edgeC_reg <= timer_reg;
        default: edgeC_reg <= edgeC_reg;
      endcase
    end
  end

  // short first interval means async; 0x91/0xa1/0xb1 land async too
  assign isAsync = (second_edge_interval_reg <= last_edge_interval);  // [R16] [R19]
  assign baudOk  = (second_edge_interval_reg >= BAUD_MIN_TICKS) &&
                   (second_edge_interval_reg <= BAUD_MAX_TICKS);

  // mode, reception enable and abort levels
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxEnable_reg <= 1'b0;
      modeSync_reg <= 1'b0;
      abort_reg    <= 1'b0;
    end else if (measDone) begin
      modeSync_reg <= !isAsync;
      rxEnable_reg <= !isAsync || baudOk;
      abort_reg    <= isAsync && !baudOk;  // [R7]
    end
  end

  // ----------------------------------------------------------------
  // link domain: byte capture and ack launch
  // ----------------------------------------------------------------
  // control levels into link domain
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      enS1_reg  <= 1'b0;
      enS2_reg  <= 1'b0;
      synS1_reg <= 1'b0;
      synS2_reg <= 1'b0;
    end else begin
      enS1_reg  <= rxEnable_reg;
      enS2_reg  <= enS1_reg;
      synS1_reg <= modeSync_reg;
      synS2_reg <= synS1_reg;
    end
  end

  // hold each received byte and flip the event toggle
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      rxHold_reg <= '0;
      rxTog_reg  <= 1'b0;
    end else if (linkRxValid && enS2_reg) begin
      rxHold_reg <= '{data: linkRxData, err: linkRxErr};
      rxTog_reg  <= !rxTog_reg;
    end
  end

  // ack toggle synchroniser in link domain
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      txTogS1_reg <= 1'b0;
      txTogS2_reg <= 1'b0;
      txTogS3_reg <= 1'b0;
    end else begin
      txTogS1_reg <= txTog_reg;
      txTogS2_reg <= txTogS1_reg;
      txTogS3_reg <= txTogS2_reg;
    end
  end

  // one-cycle ack pulse; data stable since toggle flipped
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      linkTxValid <= 1'b0;
      linkTxData  <= 8'h00;
    end else begin
      linkTxValid <= txTogS2_reg ^ txTogS3_reg;
      if (txTogS2_reg ^ txTogS3_reg) begin
        linkTxData <= txData_reg;
      end
    end
  end

  assign linkRxEnable = enS2_reg;
  assign linkSyncMode = synS2_reg;

  // ----------------------------------------------------------------
  // clk domain: byte arrival
  // ----------------------------------------------------------------
  // rx toggle synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxTogS1_reg <= 1'b0;
      rxTogS2_reg <= 1'b0;
      rxTogS3_reg <= 1'b0;
    end else begin
      rxTogS1_reg <= rxTog_reg;
      rxTogS2_reg <= rxTogS1_reg;
      rxTogS3_reg <= rxTogS2_reg;
    end
  end

  assign rxStrobe = rxTogS2_reg ^ rxTogS3_reg;
  assign rxErr    = rxHold_reg.err && !modeSync_reg;  // [R5]

  // ----------------------------------------------------------------
  // password memory
  // ----------------------------------------------------------------
  pw_store u_pw_store (
    .clk    (clk),
    .wrEn   (pwWrEn),
    .wrAddr (pwWrAddr),
    .wrData (pwWrData),
    .rdAddr (pwIdx_reg),
    .rdData (pwStored)
  );

  assign sameNow = (pwIdx_reg == PW_FIRST) || (pwStored == pwFirst_reg);
  assign areaErr = pwSame_reg && (pwFirst_reg != ERASED_BYTE);  // [R21]

  // ----------------------------------------------------------------
  // sequencer: decisions and acks
  // ----------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    cmdNib_next = cmdNib_reg;
    sendAck     = 1'b0;
    ackByte     = 8'h00;
    case (state_reg)
      ST_MEASURE: begin
        if (measDone) begin
          if (!isAsync) begin
            sendAck    = 1'b1;
            ackByte    = MODE_ACK_SYNC;  // [R6]
            state_next = ST_WAIT_CMD;
          end else if (baudOk) begin
            sendAck    = 1'b1;
            ackByte    = MODE_ACK_ASYNC;  // [R6]
            state_next = ST_WAIT_CMD;
          end else begin
            state_next = ST_ABORT;  // [R7]
          end
        end
      end
      ST_WAIT_CMD: begin
        if (rxStrobe) begin
          sendAck = 1'b1;  // [R26]
          if (rxErr) begin
            ackByte = makeAck(cmdNib_reg, 1'b1, 1'b0);  // [R9]
          end else if ((rxHold_reg.data[3:0] == CMD_LOW_NIB) &&
                       (rxHold_reg.data[7:4] >= CMD_RAM_XFER) &&
                       (rxHold_reg.data[7:4] <= CMD_CHIP_ERASE)) begin
            ackByte     = rxHold_reg.data;  // [R8]
            cmdNib_next = rxHold_reg.data[7:4];
            if (rxHold_reg.data[7:4] == CMD_RAM_XFER) begin
              state_next = ST_PW_RX;  // [R20] [R23]
            end else if (rxHold_reg.data[7:4] == CMD_CHIP_ERASE) begin
              state_next = ST_ERASE_EN;
            end
          end else begin
            ackByte = makeAck(cmdNib_reg, 1'b0, 1'b1);  // [R9] [R25]
          end
        end
      end
      ST_PW_RX: begin
        if (rxStrobe && (pwIdx_reg == PW_LAST)) begin
          state_next = ST_WAIT_CHK;
        end
      end
      ST_WAIT_CHK: begin
        if (rxStrobe) begin
          sendAck    = 1'b1;  // [R26]
          state_next = ST_WAIT_CMD;
          if (rxErr || pwRxErr_reg) begin
            ackByte = makeAck(cmdNib_reg, 1'b1, 1'b0);  // [R10]
          end else if (areaErr || pwMiss_reg) begin
            ackByte = makeAck(CMD_RAM_XFER, 1'b0, 1'b1);  // [R11] [R21] [R22]
          end else if ((sum_reg + rxHold_reg.data) != 8'h00) begin
            ackByte = makeAck(cmdNib_reg, 1'b0, 1'b1);  // [R10] [R24]
          end else begin
            ackByte = makeAck(cmdNib_reg, 1'b0, 1'b0);  // [R10]
          end
        end
      end
      ST_ERASE_EN: begin
        if (rxStrobe) begin
          sendAck    = 1'b1;
          state_next = ST_WAIT_CMD;
          if (rxErr) begin
            ackByte = makeAck(cmdNib_reg, 1'b1, 1'b0);  // [R2]
          end else if (rxHold_reg.data == ERASE_ENABLE) begin
            ackByte    = ERASE_ENABLE;  // [R12]
            state_next = ST_ERASE_RUN;
          end else begin
            ackByte = makeAck(cmdNib_reg, 1'b0, 1'b1);  // [R3] [R25]
          end
        end
      end
      ST_ERASE_RUN: begin
        if (eraseDone) begin
          sendAck    = 1'b1;
          ackByte    = eraseOk ? ERASE_DONE_OK : ERASE_DONE_BAD;  // [R12]
          state_next = ST_WAIT_CMD;
        end
      end
      ST_ABORT: begin
        state_next = ST_ABORT;  // silent until reset [R7]
      end
      default: begin
        state_next = ST_MEASURE;
      end
    endcase
  end

  // state and command nibble
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg  <= ST_MEASURE;
      cmdNib_reg <= 4'h0;
    end else begin
      state_reg  <= state_next;
      cmdNib_reg <= cmdNib_next;  // [R1]
    end
  end

  // ack launch toward link domain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txData_reg <= 8'h00;
      txTog_reg  <= 1'b0;
    end else if (sendAck) begin
      txData_reg <= ackByte;
      txTog_reg  <= !txTog_reg;
    end
  end

  // password index, comparison and area scan
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwIdx_reg   <= PW_FIRST;
      pwFirst_reg <= 8'h00;
      pwSame_reg  <= 1'b1;
      pwMiss_reg  <= 1'b0;
      pwRxErr_reg <= 1'b0;
      sum_reg     <= 8'h00;
    end else if (state_reg != ST_PW_RX) begin
      if (state_reg == ST_WAIT_CMD) begin
        pwIdx_reg   <= PW_FIRST;  // fresh start per transfer
        pwSame_reg  <= 1'b1;
        pwMiss_reg  <= 1'b0;
        pwRxErr_reg <= 1'b0;
        sum_reg     <= 8'h00;
      end
    end else if (rxStrobe) begin
      if (pwIdx_reg == PW_FIRST) begin
        pwFirst_reg <= pwStored;
      end
      pwSame_reg  <= pwSame_reg && sameNow;  // [R21]
      pwMiss_reg  <= pwMiss_reg || (rxHold_reg.data != pwStored);  // [R22]
      pwRxErr_reg <= pwRxErr_reg || rxErr;  // [R2]
      sum_reg     <= sum_reg + rxHold_reg.data;  // [R24]
      if (pwIdx_reg != PW_LAST) begin
        pwIdx_reg <= pwIdx_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // outward requests
  // ----------------------------------------------------------------
  // one-cycle pulses: erase start, other operation start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eraseReq_reg <= 1'b0;
      opStart_reg  <= 1'b0;
      opCode_reg   <= 8'h00;
    end else begin
      eraseReq_reg <= (state_reg == ST_ERASE_EN) && (state_next == ST_ERASE_RUN);
      opStart_reg  <= sendAck && (ackByte == {cmdNib_next, CMD_LOW_NIB}) &&
                      (state_reg != ST_MEASURE) && (state_reg != ST_ERASE_RUN) &&
                      (state_reg != ST_ERASE_EN) &&
                      ((state_reg != ST_WAIT_CHK) || (ackByte[ACK_BAD_BIT] == 1'b0));
      if (sendAck) begin
        opCode_reg <= ackByte;
      end
    end
  end

  assign eraseReq  = eraseReq_reg;
  assign opStart   = opStart_reg;
  assign opCode    = opCode_reg;
  assign modeSync  = modeSync_reg;
  assign bootAbort = abort_reg;

endmodule // boot_ack_ctrl

// ==== hdl/boot_ack_pkg.sv ====
// constants, types and states of the serial boot acknowledge front end
// Summary of operation
// R1: ack upper nibble is executing command's nibble
// R2: ack bit 3 flags a reception error
// R3: ack bit 0 flags invalid, checksum, password error
// R4: ack bits 1 and 2 always zero; the code sets bit 2 in its 0x86, 0x54, 0x4F and 0x4C answers
// R5: no reception error check in clocked mode
// R6: mode byte answered 0x86 async, 0x30 clocked
// R7: unusable async baud rate aborts silently
// R8: valid commands echoed 0x10, 0x20, 0x30, 0x40
// R9: command error nibble 8, undefined nibble 1
// R10: checksum ack nibble 0 ok, 1 bad, 8 error
// R11: password failure ack upper nibble is 1
// R12: erase exchange answers 0x54, then 0x4F or 0x4C
// R13: controller sends 0x86 at async baud rate
// R14: controller sends 0x30 at one sixteenth rate
// R15: capture timer at each first-byte edge, reception off
// R16: first interval not above last means async
// R17: controller times out waiting for 0x86 echo
// R18: controller clocks ack, stops unless 0x30
// R19: 0x91, 0xa1, 0xb1 also select clocked mode; the code treats them as async (first interval not above last)
// R20: ram transfer echo triggers 12-byte password check
// R21: uniform non-0xff stored password gives 0x11
// R22: password bytes five to sixteen must all match
// R23: password checked even with security enabled
// R24: checksum is two's complement of byte sum
// R25: invalid command returns to command wait
// R26: ack only after answered byte fully checked
package boot_ack_pkg;

  // ----------------------------------------------------------------
  // acknowledge byte layout
  // ----------------------------------------------------------------
  localparam int ACK_ERR_BIT  = 3;               // reception error flag
  localparam int ACK_BAD_BIT  = 0;               // invalid / checksum / password flag
  localparam logic [1:0] ACK_ZERO_BITS = 2'h0;   // bits 2 and 1

  // ----------------------------------------------------------------
  // byte codes
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_ACK_ASYNC = 8'h86;  // async mode answer
  localparam logic [7:0] MODE_ACK_SYNC  = 8'h30;  // clocked mode answer
  localparam logic [3:0] CMD_RAM_XFER   = 4'h1;   // command nibbles
  localparam logic [3:0] CMD_FLASH_SUM  = 4'h2;
  localparam logic [3:0] CMD_PROD_INFO  = 4'h3;
  localparam logic [3:0] CMD_CHIP_ERASE = 4'h4;
  localparam logic [3:0] CMD_LOW_NIB    = 4'h0;   // low nibble of valid commands
  localparam logic [7:0] ERASE_ENABLE   = 8'h54;  // erase-enable byte and echo
  localparam logic [7:0] ERASE_DONE_OK  = 8'h4f;  // erase completed
  localparam logic [7:0] ERASE_DONE_BAD = 8'h4c;  // erase ended abnormally
  localparam logic [7:0] ERASED_BYTE    = 8'hff;  // blank flash content

  // ----------------------------------------------------------------
  // password area
  // ----------------------------------------------------------------
  localparam int PW_BYTES = 12;
  localparam int PW_AW    = 4;
  localparam logic [PW_AW-1:0] PW_LAST = 4'hb;    // index of last password byte
  localparam logic [PW_AW-1:0] PW_FIRST = 4'h0;

  // ----------------------------------------------------------------
  // edge timer and accepted async bit-time window, in clk ticks
  // ----------------------------------------------------------------
  localparam int TMR_W = 16;
  localparam logic [TMR_W-1:0] BAUD_MIN_TICKS = 16'h0010;
  localparam logic [TMR_W-1:0] BAUD_MAX_TICKS = 16'hf000;
  localparam logic [1:0] EDGE_LAST = 2'h3;        // fourth edge index

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;  // received byte
    logic       err;   // framing / overrun seen by the serial port unit
  } rx_byte_s;

  typedef enum logic [3:0] {
    ST_MEASURE   = 4'b0000,  // timing the first byte
    ST_WAIT_CMD  = 4'b0001,  // waiting for a command byte
    ST_PW_RX     = 4'b0011,  // taking password bytes
    ST_WAIT_CHK  = 4'b0010,  // waiting for the checksum byte
    ST_ERASE_EN  = 4'b0110,  // waiting for the erase-enable byte
    ST_ERASE_RUN = 4'b0111,  // erase in progress outside
    ST_ABORT     = 4'b0101   // boot given up, silent
  } boot_state_e;

endpackage

// ==== hdl/pw_store.sv ====
// twelve-byte stored password memory with registered read
`timescale 1ns/1ps
module pw_store (
  input  wire logic                            clk,
  input  wire logic                            wrEn,
  input  wire logic [boot_ack_pkg::PW_AW-1:0]  wrAddr,
  input  wire logic [7:0]                      wrData,
  input  wire logic [boot_ack_pkg::PW_AW-1:0]  rdAddr,
  output logic      [7:0]                      rdData
);
  import boot_ack_pkg::*;

  logic [7:0] mem [PW_BYTES];  // password bytes

  // write port, out-of-range addresses dropped
  always_ff @(posedge clk) begin
    if (wrEn && (wrAddr <= PW_LAST)) begin
      mem[wrAddr] <= wrData;
    end
  end

  // registered read
  always_ff @(posedge clk) begin
    rdData <= (rdAddr <= PW_LAST) ? mem[rdAddr] : ERASED_BYTE;
  end

endmodule // pw_store
